/* File: hdl/ccc_counters.sv */
// Purpose: Counter bank of a clock/calendar with event-counter mode
// Assumes: Byte register port driven by a serial-bus slave on clk_sys
// Notes:   Reads of 01..07 return values captured at the read-cycle start
//
// Summary of operation
// - Hours register top bit selects 12-hour or 24-hour counting.
// - Year and BCD date share the byte at location 05.
// - Weekday and BCD month share the byte at location 06.
// - Mask flag set hides year and weekday fields on reads.
// - Event mode keeps six BCD digits, least significant first.
// - Event mode bypasses the divider; each event increments directly.
// - Clock counters wrap and carry at their documented limits.
// - Date wraps by month length, February by leap year zero.
// - Timer counts 00 to 99 and never carries onward.
// - Alarm control takes effect only while alarm enable is set.
// - Alarm control governs alarm, timer and interrupt functions.
// - Control/status selects crystal, 50 Hz or event-counter mode.
// - Read-cycle start latches all counters into capture registers.
// - Writing one counter leaves all others unchanged.
// - Crystal mode advances counters on a 100 Hz tick.
`timescale 1ns/10ps
module ccc_counters
    import ccc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       ce,
    input  wire logic       tick_100hz,
    input  wire logic       osc_in_pin,
    input  wire logic       rd_start,
    input  wire logic       rd_en,
    input  wire logic       wr_en,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] rd_data,
    output logic      [7:0] alarm_ctrl_active,
    output logic            timer_wrap
);
    import ccc_pkg::*;

    logic [7:0] cnt_ff [0:7];
    logic [7:0] nxt_cnt [0:7];
    logic [7:0] cap_ff [1:7];
    logic [7:0] nxt_cap [1:7];
    logic [7:0] actl_ff, nxt_actl;
    logic [7:0] rd_data_ff, nxt_rd_data;
    logic [7:0] actl_act_ff, nxt_actl_act;
    logic       twrap_ff, nxt_twrap;
    logic [2:0] pin_ff, nxt_pin;

    ccc_mode_t mode;
    logic      tick_clk;
    logic      tick_evt;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    assign mode = ccc_mode_t'(cnt_ff[0][CS_MODE_LSB +: 2]);

    // Pin edges: 50 Hz reference counts both edges to form 100 Hz
    always_comb begin
        tick_clk = 1'b0;
        tick_evt = 1'b0;
        unique case (mode)
            MODE_XTAL:  tick_clk = tick_100hz;
            MODE_F50:   tick_clk = pin_ff[1] ^ pin_ff[2];
            MODE_EVENT: tick_evt = pin_ff[1] & ~pin_ff[2];
            default:    tick_clk = 1'b0;
        endcase
        if (cnt_ff[0][CS_STOP_BIT]) begin
            tick_clk = 1'b0;
            tick_evt = 1'b0;
        end
    end

    always_comb begin
        logic       c_hund, c_sec, c_min, c_day, t_inc;
        logic [5:0] hr, dmax;
        logic [4:0] mon;
        logic [2:0] tsel;
        logic [23:0] ev;
        logic [7:0] hr_inc, mon_inc, date_inc;
        c_hund = 1'b0;
        c_sec  = 1'b0;
        c_min  = 1'b0;
        c_day  = 1'b0;
        t_inc  = 1'b0;
        hr     = cnt_ff[4][5:0];
        mon    = cnt_ff[6][4:0];
        dmax   = DATE_31;
        tsel   = 3'h0;
        ev     = {cnt_ff[3], cnt_ff[2], cnt_ff[1]};
        // Increments worked out once, sliced where used
        hr_inc   = bcd_inc({2'b00, hr});
        mon_inc  = bcd_inc({3'b000, mon});
        date_inc = bcd_inc({2'b00, cnt_ff[5][5:0]});
        nxt_pin = {pin_ff[1:0], osc_in_pin};
        for (int i = 0; i < 8; i++) begin
            nxt_cnt[i] = cnt_ff[i];
        end
        nxt_actl  = actl_ff;
        nxt_twrap = 1'b0;
        // Alarm control is inert unless alarm enable is set
        nxt_actl_act = cnt_ff[0][CS_AL_EN_BIT] ? actl_ff : RST_ZERO;
        tsel = actl_act_ff[AC_TSEL_LSB +: 3];

        if (tick_clk) begin
            nxt_cnt[1] = (cnt_ff[1] == LIM_HUND) ? RST_ZERO : bcd_inc(cnt_ff[1]);
            c_hund = (cnt_ff[1] == LIM_HUND);
            if (c_hund) begin
                c_sec = (cnt_ff[2] == LIM_SIXTY);
                nxt_cnt[2] = c_sec ? RST_ZERO : bcd_inc(cnt_ff[2]);
            end
            if (c_sec) begin
                c_min = (cnt_ff[3] == LIM_SIXTY);
                nxt_cnt[3] = c_min ? RST_ZERO : bcd_inc(cnt_ff[3]);
            end
            if (c_min) begin
                if (cnt_ff[4][HR_FMT12_BIT]) begin
                    // 12 h: 12 -> 01, 11 -> 12 flips AM/PM
                    if (hr == H12_TOP) begin
                        nxt_cnt[4][5:0] = 6'h01;
                    end else begin
                        nxt_cnt[4][5:0] = hr_inc[5:0];
                    end
                    if (hr == H12_TURN) begin
                        nxt_cnt[4][HR_PM_BIT] = ~cnt_ff[4][HR_PM_BIT];
                        c_day = cnt_ff[4][HR_PM_BIT];
                    end
                end else begin
                    c_day = (hr == LIM_H24);
                    nxt_cnt[4][5:0] = c_day ? 6'h00 : hr_inc[5:0];
                end
            end
            if (c_day) begin
                // Month length picks the date wrap point
                if (mon == 5'h02) begin
                    dmax = (cnt_ff[5][7:6] == 2'd0) ? DATE_29 : DATE_28;
                end else if (mon == 5'h04 || mon == 5'h06 || mon == 5'h09 || mon == 5'h11) begin
                    dmax = DATE_30;
                end
                nxt_cnt[6][7:5] = (cnt_ff[6][7:5] == LIM_WDAY) ? 3'h0 : cnt_ff[6][7:5] + 3'h1;
                if (cnt_ff[5][5:0] == dmax) begin
                    nxt_cnt[5][5:0] = 6'h01;
                    if (mon == LIM_MONTH) begin
                        nxt_cnt[6][4:0] = 5'h01;
                        nxt_cnt[5][7:6] = cnt_ff[5][7:6] + 2'd1;
                    end else begin
                        nxt_cnt[6][4:0] = mon_inc[4:0];
                    end
                end else begin
                    nxt_cnt[5][5:0] = date_inc[5:0];
                end
            end
            unique case (tsel)
                TSEL_HUND: t_inc = 1'b1;
                TSEL_SEC:  t_inc = c_hund;
                TSEL_MIN:  t_inc = c_sec;
                TSEL_HOUR: t_inc = c_min;
                default:   t_inc = c_day;
            endcase
            if (t_inc) begin
                nxt_twrap  = (cnt_ff[7] == LIM_HUND);
                nxt_cnt[7] = nxt_twrap ? RST_ZERO : bcd_inc(cnt_ff[7]);
            end
        end

        if (tick_evt) begin
            // Ripple through six digits, low digit first
            if (ev == LIM_EVENT) begin
                ev = 24'h000000;
            end else begin
                for (int d = 0; d < 6; d++) begin
                    if (ev[d*4 +: 4] == 4'h9) begin
                        ev[d*4 +: 4] = 4'h0;
                    end else begin
                        ev[d*4 +: 4] = ev[d*4 +: 4] + 4'h1;
                        break;
                    end
                end
            end
            {nxt_cnt[3], nxt_cnt[2], nxt_cnt[1]} = ev;
        end

        // A write overrides only its own location
        if (wr_en) begin
            if (addr <= OFS_TIMER) begin
                nxt_cnt[addr[2:0]] = wr_data;
            end else if (addr == OFS_ALARM_CONTROL) begin
                nxt_actl = wr_data;
            end
        end

        for (int i = 1; i < 8; i++) begin
            nxt_cap[i] = rd_start ? cnt_ff[i] : cap_ff[i];
        end

        nxt_rd_data = rd_data_ff;
        if (rd_en) begin
            if (addr == OFS_CTRL_STATUS) begin
                nxt_rd_data = cnt_ff[0];
            end else if (addr <= OFS_TIMER) begin
                nxt_rd_data = cap_ff[addr[2:0]];
                if (cnt_ff[0][CS_MASK_BIT] && addr == OFS_YEAR_DATE) begin
                    nxt_rd_data[7:6] = 2'b00;
                end
                if (cnt_ff[0][CS_MASK_BIT] && addr == OFS_WEEKDAY_MONTH) begin
                    nxt_rd_data[7:5] = 3'b000;
                end
            end else if (addr == OFS_ALARM_CONTROL) begin
                nxt_rd_data = actl_ff;
            end else begin
                nxt_rd_data = RST_ZERO;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_ff[0] <= RST_CTRL_STATUS;
            cnt_ff[1] <= RST_ZERO;
            cnt_ff[2] <= RST_ZERO;
            cnt_ff[3] <= RST_ZERO;
            cnt_ff[4] <= RST_ZERO;
            cnt_ff[5] <= RST_YEAR_DATE;
            cnt_ff[6] <= RST_WDAY_MONTH;
            cnt_ff[7] <= RST_ZERO;
            for (int i = 1; i < 8; i++) begin
                cap_ff[i] <= RST_ZERO;
            end
            actl_ff     <= RST_ZERO;
            actl_act_ff <= RST_ZERO;
            rd_data_ff  <= RST_ZERO;
            twrap_ff    <= 1'b0;
            pin_ff      <= 3'b000;
        end else if (ce) begin
            for (int i = 0; i < 8; i++) begin
                cnt_ff[i] <= nxt_cnt[i];
            end
            for (int i = 1; i < 8; i++) begin
                cap_ff[i] <= nxt_cap[i];
            end
            actl_ff     <= nxt_actl;
            actl_act_ff <= nxt_actl_act;
            rd_data_ff  <= nxt_rd_data;
            twrap_ff    <= nxt_twrap;
            pin_ff      <= nxt_pin;
        end
    end

    assign rd_data           = rd_data_ff;
    assign alarm_ctrl_active = actl_act_ff;
    assign timer_wrap        = twrap_ff;
endmodule

/* File: include/ccc_pkg.sv */
// Purpose: Constants for the clock/calendar counter bank
// Assumes: Byte-wide register port, offsets as memory locations
// Notes:   Control/status bit positions and timer unit codes are local picks
package ccc_pkg;
    // Register offsets
    localparam logic [7:0] OFS_CTRL_STATUS   = 8'h00;
    localparam logic [7:0] OFS_HUNDREDTHS    = 8'h01;
    localparam logic [7:0] OFS_SECONDS       = 8'h02;
    localparam logic [7:0] OFS_MINUTES       = 8'h03;
    localparam logic [7:0] OFS_HOURS         = 8'h04;
    localparam logic [7:0] OFS_YEAR_DATE     = 8'h05;
    localparam logic [7:0] OFS_WEEKDAY_MONTH = 8'h06;
    localparam logic [7:0] OFS_TIMER         = 8'h07;
    localparam logic [7:0] OFS_ALARM_CONTROL = 8'h08;
    // Control/status fields
    localparam int CS_STOP_BIT   = 7;
    localparam int CS_MODE_LSB   = 4;
    localparam int CS_MASK_BIT   = 3;
    localparam int CS_AL_EN_BIT  = 2;
    // Hours fields
    localparam int HR_FMT12_BIT  = 7;
    localparam int HR_PM_BIT     = 6;
    // Alarm control timer unit field
    localparam int AC_TSEL_LSB   = 0;
    localparam logic [2:0] TSEL_HUND = 3'h1;
    localparam logic [2:0] TSEL_SEC  = 3'h2;
    localparam logic [2:0] TSEL_MIN  = 3'h3;
    localparam logic [2:0] TSEL_HOUR = 3'h4;
    // Reset values
    localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
    localparam logic [7:0] RST_ZERO        = 8'h00;
    localparam logic [7:0] RST_YEAR_DATE   = 8'h01;
    localparam logic [7:0] RST_WDAY_MONTH  = 8'h01;
    // Counter limits (BCD)
    localparam logic [7:0] LIM_HUND  = 8'h99;
    localparam logic [7:0] LIM_SIXTY = 8'h59;
    localparam logic [5:0] LIM_H24   = 6'h23;
    localparam logic [5:0] H12_TOP   = 6'h12;
    localparam logic [5:0] H12_TURN  = 6'h11;
    localparam logic [4:0] LIM_MONTH = 5'h12;
    localparam logic [2:0] LIM_WDAY  = 3'h6;
    localparam logic [5:0] DATE_31   = 6'h31;
    localparam logic [5:0] DATE_30   = 6'h30;
    localparam logic [5:0] DATE_29   = 6'h29;
    localparam logic [5:0] DATE_28   = 6'h28;
    localparam logic [23:0] LIM_EVENT = 24'h999999;

    typedef enum logic [1:0] {
        MODE_XTAL  = 2'b00,
        MODE_F50   = 2'b01,
        MODE_EVENT = 2'b10
    } ccc_mode_t;
endpackage

/* File: test/ccc_checker.sv */
// Purpose: Port assertions for ccc_counters
// Assumes: Shadows of loc 00 and 08 follow the writes
// Notes:   Captured counter values are judged by the bench
`timescale 1ns/10ps
module ccc_checker
    import ccc_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       rstn,
    input wire logic       ce,
    input wire logic       rd_en,
    input wire logic       wr_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] alarm_ctrl_active,
    input wire logic       timer_wrap
);
    logic [7:0] cs_ff, nxt_cs, ac_ff, nxt_ac;
    always_comb begin
        nxt_cs = cs_ff;
        nxt_ac = ac_ff;
        if (ce && wr_en && addr == OFS_CTRL_STATUS) nxt_cs = wr_data;
        if (ce && wr_en && addr == OFS_ALARM_CONTROL) nxt_ac = wr_data;
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cs_ff <= RST_CTRL_STATUS;
            ac_ff <= RST_ZERO;
        end else begin
            cs_ff <= nxt_cs;
            ac_ff <= nxt_ac;
        end
    end
    wire logic [7:0] act_exp = cs_ff[CS_AL_EN_BIT] ? ac_ff : 8'h00;
    // Stopped, event or idle mode: the timer may not move
    wire logic       halt    = cs_ff[CS_STOP_BIT] | cs_ff[CS_MODE_LSB+1];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    rd_hold_a: assert property (!(ce && rd_en) |=> $stable(rd_data))
        else $error("rd_data moved without a read");
    bad_addr_a: assert property (ce && rd_en && addr > 8'h08 |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    ctrl_read_a: assert property (ce && rd_en && addr == 8'h00 |=> rd_data == $past(cs_ff))
        else $error("control read wrong");
    ac_read_a: assert property (ce && rd_en && addr == 8'h08 |=> rd_data == $past(ac_ff))
        else $error("alarm control read wrong");
    alarm_gate_a: assert property ($past(ce) |-> alarm_ctrl_active == $past(act_exp))
        else $error("alarm control gating wrong");
    stop_wrap_a: assert property (ce && halt |=> !timer_wrap)
        else $error("timer wrapped while halted");
    wrap_pulse_a: assert property (timer_wrap && ce |=> !timer_wrap)
        else $error("timer_wrap longer than a cycle");
    ce_freeze_a: assert property (!ce |=> $stable(rd_data) && $stable(timer_wrap)
        && $stable(alarm_ctrl_active))
        else $error("state moved with ce low");
endmodule
bind ccc_counters ccc_checker i_chk (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .rd_en(rd_en),
    .wr_en(wr_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
    .alarm_ctrl_active(alarm_ctrl_active), .timer_wrap(timer_wrap));

/* File: test/ccc_host.sv */
// Purpose: Controller side that sets and reads the counters
// Assumes: Byte port of ccc_counters, one request at a time
// Notes:   Idle address and data are inverted so stale values never match
`timescale 1ns/10ps
module ccc_host (
    input  wire logic       clk_sys,
    input  wire logic [7:0] rd_data,
    output logic            rd_start,
    output logic            rd_en,
    output logic            wr_en,
    output logic      [7:0] addr,
    output logic      [7:0] wr_data
);
    initial {rd_start, rd_en, wr_en, addr, wr_data} = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        {wr_en, addr, wr_data} <= {1'b1, a, d};
        @(posedge clk_sys);
        {wr_en, addr, wr_data} <= {1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        rd_start <= 1'b1;
        @(posedge clk_sys);
        {rd_start, rd_en, addr} <= {2'b01, a};
        @(posedge clk_sys);
        {rd_en, addr} <= {1'b0, ~a};
        #1 d = rd_data;
    endtask
endmodule

/* File: test/ccc_counters_test.sv */
// Purpose: Self-checking bench for ccc_counters
// Assumes: Host model drives the byte port, bench drives ticks and pin
// Notes:   Counters are stopped while set, so reads are exact
`timescale 1ns/10ps
module ccc_counters_test;
    import ccc_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q;} ccc_row_t;
    logic       clk_sys, rstn, ce, tick_100hz, osc_in_pin, rd_start, rd_en, wr_en, timer_wrap;
    logic [7:0] addr, wr_data, rd_data, alarm_ctrl_active, v, n;
    int         fails, compares;
    ccc_row_t   rows [9] = '{'{8'h01, 8'h99, 8'h99}, '{8'h02, 8'h59, 8'h59},
        '{8'h03, 8'h59, 8'h59}, '{8'h04, 8'h23, 8'h23}, '{8'h05, 8'hd1, 8'hd1},
        '{8'h06, 8'hb2, 8'hb2}, '{8'h07, 8'h99, 8'h99}, '{8'h09, 8'h55, 8'h00},
        '{8'h08, 8'h5a, 8'h5a}};
    ccc_counters i_dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .tick_100hz(tick_100hz),
        .osc_in_pin(osc_in_pin), .rd_start(rd_start), .rd_en(rd_en), .wr_en(wr_en),
        .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
        .alarm_ctrl_active(alarm_ctrl_active), .timer_wrap(timer_wrap));
    ccc_host i_host (.clk_sys(clk_sys), .rd_data(rd_data), .rd_start(rd_start),
        .rd_en(rd_en), .wr_en(wr_en), .addr(addr), .wr_data(wr_data));
    task automatic end_sim();
        if (fails == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        i_host.rd(a, v);
        chk($sformatf("loc %h", a), v, e);
    endtask
    task automatic tk();
        @(posedge clk_sys) tick_100hz <= 1'b1;
        @(posedge clk_sys) tick_100hz <= 1'b0;
    endtask
    task automatic pin();
        @(posedge clk_sys) osc_in_pin <= ~osc_in_pin;
        repeat (5) @(posedge clk_sys);
    endtask
    // One tick from hh:59:59.99, then stopped again for reading
    task automatic roll(input logic [7:0] h);
        i_host.wr(8'h01, 8'h99);
        i_host.wr(8'h02, 8'h59);
        i_host.wr(8'h03, 8'h59);
        i_host.wr(8'h04, h);
        i_host.wr(8'h00, 8'h00);
        tk();
        i_host.wr(8'h00, 8'h80);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        end_sim();
    end
    initial begin
        {rstn, ce, tick_100hz, osc_in_pin} = 4'b0100;
        repeat (10) @(posedge clk_sys);
        chk("reset rd_data", rd_data, RST_ZERO);
        chk("reset alarm", alarm_ctrl_active, RST_ZERO);
        chk("reset wrap", {7'h0, timer_wrap}, 8'h00);
        rstn <= 1'b1;
        rc(8'h05, RST_YEAR_DATE);
        rc(8'h06, RST_WDAY_MONTH);
        i_host.wr(8'h00, 8'h80);
        foreach (rows[i]) i_host.wr(rows[i].a, rows[i].d);
        foreach (rows[i]) rc(rows[i].a, rows[i].q);
        i_host.wr(8'h00, 8'h88);
        rc(8'h05, 8'h11);
        rc(8'h06, 8'h12);
        i_host.wr(8'h05, 8'h28);
        i_host.wr(8'h06, 8'hc2);
        roll(8'h23);
        foreach (rows[i]) if (i < 4) rc(rows[i].a, 8'h00);
        rc(8'h05, 8'h29);
        rc(8'h06, 8'h02);
        roll(8'h23);
        rc(8'h05, 8'h01);
        rc(8'h06, 8'h23);
        roll(8'h91);
        rc(8'h04, 8'hd2);
        roll(8'hd1);
        rc(8'h04, 8'h92);
        rc(8'h05, 8'h02);
        i_host.wr(8'h01, 8'h99);
        i_host.wr(8'h02, 8'h99);
        i_host.wr(8'h03, 8'h00);
        i_host.wr(8'h00, 8'h20);
        pin();
        i_host.wr(8'h00, 8'ha0);
        rc(8'h01, 8'h00);
        rc(8'h03, 8'h01);
        i_host.wr(8'h00, 8'h10);
        pin();
        pin();
        i_host.wr(8'h00, 8'h90);
        rc(8'h01, 8'h02);
        // Mode 11 must count neither pin edges nor ticks
        i_host.wr(8'h00, 8'h30);
        pin();
        tk();
        i_host.wr(8'h00, 8'hb0);
        rc(8'h01, 8'h02);
        i_host.wr(8'h07, 8'h99);
        i_host.wr(8'h08, TSEL_HUND);
        i_host.wr(8'h00, 8'h04);
        // Gated copy lags the control write by one cycle
        @(posedge clk_sys);
        #1 chk("alarm active", alarm_ctrl_active, 8'h01);
        // A tick under ce low must be lost, so only one wrap follows
        @(posedge clk_sys) {ce, tick_100hz} <= 2'b01;
        @(posedge clk_sys) {ce, tick_100hz} <= 2'b10;
        @(posedge clk_sys) tick_100hz <= 1'b1;
        n = 8'h00;
        repeat (4) begin
            @(posedge clk_sys) tick_100hz <= 1'b0;
            #1 n += {7'h0, timer_wrap};
        end
        chk("timer_wrap", n, 8'h01);
        i_host.wr(8'h00, 8'h80);
        rc(8'h07, 8'h00);
        chk("alarm active", alarm_ctrl_active, 8'h00);
        end_sim();
    end
endmodule
